/* design/sbs_core.sv */
// Purpose: Command decode, burst address and data path of a
//          zero-turnaround late-write synchronous SRAM
// Assumes: Controller shares sys_clk_i; all pins synchronous except sys_rst_i
// Notes:   Output enable is sampled with the command, not async
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_core #(
  parameter int ADDR_W    = `SBS_ADDR_W,
  parameter int LANE_W    = `SBS_LANE_W,
  parameter int BUF_DEPTH = `SBS_BUF_DEPTH
) (
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clock_enable_n_i,
  input  wire logic              chip_enable_low_a_n_i,
  input  wire logic              chip_enable_high_i,
  input  wire logic              chip_enable_low_b_n_i,
  input  wire logic              advance_or_load_i,
  input  wire logic              read_write_n_i,
  input  wire logic              byte_lane_a_write_n_i,
  input  wire logic              byte_lane_b_write_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              burst_order_select_i,
  input  wire logic              flowthrough_select_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [LANE_W-1:0] data_lane_a_i,
  input  wire logic [LANE_W-1:0] data_lane_b_i,
  output logic      [LANE_W-1:0] data_lane_a_o,
  output logic      [LANE_W-1:0] data_lane_b_o,
  output logic                   data_oe_o,
  output logic                   wr_buf_ready_o
);
  localparam int DW = `SBS_LANES * LANE_W;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(BUF_DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(BUF_DEPTH - 1);

  logic en;
  logic load;
  logic sel;
  logic [`SBS_LANES-1:0] be_in;

  assign en    = ~clock_enable_n_i;
  assign load  = ~advance_or_load_i;
  assign sel   = ~chip_enable_low_a_n_i & chip_enable_high_i & ~chip_enable_low_b_n_i;
  assign be_in = ~{byte_lane_b_write_n_i, byte_lane_a_write_n_i};

  // Burst state
  sbs_pkg::sbs_op_t         op_r;
  sbs_pkg::sbs_op_t         op_nxt;
  logic [ADDR_W-1:0]        base_r;
  logic [ADDR_W-1:0]        base_nxt;
  logic [`SBS_CNT_W-1:0]    cnt_r;
  logic [`SBS_CNT_W-1:0]    cnt_nxt;
  logic [`SBS_CNT_W-1:0]    low;
  logic [ADDR_W-1:0]        cur_addr;
  sbs_pkg::sbs_slot_t       cur_slot;

  always_comb begin
    op_nxt   = op_r;
    base_nxt = base_r;
    cnt_nxt  = cnt_r;
    if (en) begin
      if (load) begin
        base_nxt = addr_i;
        cnt_nxt  = '0;
        if (!sel) begin
          op_nxt = sbs_pkg::SBS_DESEL;
        end else if (read_write_n_i) begin
          op_nxt = sbs_pkg::SBS_READ;
        end else begin
          op_nxt = sbs_pkg::SBS_WRITE;
        end
      end else begin
        // Inputs other than lane and output enables are not looked at here
        cnt_nxt = cnt_r + 2'h1;
      end
    end
  end

  always_comb begin
    if (burst_order_select_i) begin
      low = base_nxt[`SBS_CNT_W-1:0] ^ cnt_nxt;
    end else begin
      low = base_nxt[`SBS_CNT_W-1:0] + cnt_nxt;
    end
    cur_addr = {base_nxt[ADDR_W-1:`SBS_CNT_W], low};
  end
  // Operation of this edge, from this edge's command or the latched burst type
  always_comb begin
    cur_slot = '0;
    unique case (op_nxt)
      sbs_pkg::SBS_DESEL: cur_slot = '0;
      sbs_pkg::SBS_READ: begin
        cur_slot.rd    = 1'b1;
        cur_slot.drive = ~output_enable_n_i;
      end
      sbs_pkg::SBS_WRITE: cur_slot.be = be_in;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      op_r   <= sbs_pkg::SBS_DESEL;
      base_r <= '0;
      cnt_r  <= '0;
    end else begin
      op_r   <= op_nxt;
      base_r <= base_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // Command pipeline
  sbs_pkg::sbs_slot_t p1_r;
  sbs_pkg::sbs_slot_t p1_nxt;
  sbs_pkg::sbs_slot_t p2_r;
  sbs_pkg::sbs_slot_t p2_nxt;
  logic [ADDR_W-1:0]  a1_r;
  logic [ADDR_W-1:0]  a1_nxt;
  logic [ADDR_W-1:0]  a2_r;
  logic [ADDR_W-1:0]  a2_nxt;

  always_comb begin
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    a1_nxt = a1_r;
    a2_nxt = a2_r;
    if (en) begin
      p1_nxt = cur_slot;
      a1_nxt = cur_addr;
      p2_nxt = p1_r;
      a2_nxt = a1_r;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p1_r <= '0;
      p2_r <= '0;
      a1_r <= '0;
      a2_r <= '0;
    end else begin
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      a1_r <= a1_nxt;
      a2_r <= a2_nxt;
    end
  end

  // Write buffer: late write data waits here for the array port
  logic [DW-1:0]         bd_r [BUF_DEPTH];
  logic [DW-1:0]         bd_nxt [BUF_DEPTH];
  logic [ADDR_W-1:0]     ba_r [BUF_DEPTH];
  logic [ADDR_W-1:0]     ba_nxt [BUF_DEPTH];
  logic [`SBS_LANES-1:0] bb_r [BUF_DEPTH];
  logic [`SBS_LANES-1:0] bb_nxt [BUF_DEPTH];
  logic [PW-1:0]         bwp_r;
  logic [PW-1:0]         bwp_nxt;
  logic [PW-1:0]         brp_r;
  logic [PW-1:0]         brp_nxt;
  logic [CW-1:0]         bcnt_r;
  logic [CW-1:0]         bcnt_nxt;
  logic                  rdy_nxt;
  logic                  push;
  logic                  pop;

  // Array port stalls with the clock enable, so no write is inhibited
  assign push = en & (|p2_r.be) & wr_buf_ready_o;
  assign pop  = en & (bcnt_r != '0);

  always_comb begin
    bd_nxt   = bd_r;
    ba_nxt   = ba_r;
    bb_nxt   = bb_r;
    bwp_nxt  = bwp_r;
    brp_nxt  = brp_r;
    bcnt_nxt = bcnt_r;
    if (push) begin
      bd_nxt[bwp_r] = {data_lane_b_i, data_lane_a_i};
      ba_nxt[bwp_r] = a2_r;
      bb_nxt[bwp_r] = p2_r.be;
      bwp_nxt = (bwp_r == LAST_PTR) ? '0 : bwp_r + PW'(1);
    end
    if (pop) begin
      brp_nxt = (brp_r == LAST_PTR) ? '0 : brp_r + PW'(1);
    end
    if (push && !pop) begin
      bcnt_nxt = bcnt_r + CW'(1);
    end else if (pop && !push) begin
      bcnt_nxt = bcnt_r - CW'(1);
    end
    rdy_nxt = (bcnt_nxt != FULL_CNT);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        bd_r[i] <= '0;
        ba_r[i] <= '0;
        bb_r[i] <= '0;
      end
      bwp_r          <= '0;
      brp_r          <= '0;
      bcnt_r         <= '0;
      wr_buf_ready_o <= 1'b1;
    end else begin
      bd_r           <= bd_nxt;
      ba_r           <= ba_nxt;
      bb_r           <= bb_nxt;
      bwp_r          <= bwp_nxt;
      brp_r          <= brp_nxt;
      bcnt_r         <= bcnt_nxt;
      wr_buf_ready_o <= rdy_nxt;
    end
  end

  // Read source: one stage later in pipelined mode
  sbs_pkg::sbs_slot_t src;
  logic [ADDR_W-1:0]  src_addr;
  wire  [DW-1:0]      rd_word;

  assign src      = flowthrough_select_n_i ? p1_r : cur_slot;
  assign src_addr = flowthrough_select_n_i ? a1_r : cur_addr;

  // Per lane array with forwarding of writes not yet in it
  for (genvar g = 0; g < `SBS_LANES; g++) begin : g_lane
    logic [LANE_W-1:0] mem [2**ADDR_W];
    logic [LANE_W-1:0] pin_w;
    logic [LANE_W-1:0] word;

    assign pin_w = (g == 0) ? data_lane_a_i : data_lane_b_i;

    always_comb begin
      word = mem[src_addr];
      if (bcnt_r != '0 && ba_r[brp_r] == src_addr && bb_r[brp_r][g]) begin
        word = bd_r[brp_r][g*LANE_W +: LANE_W];
      end
      if (push && p2_r.be[g] && a2_r == src_addr) begin
        word = pin_w;
      end
    end

    assign rd_word[g*LANE_W +: LANE_W] = word;

    always_ff @(posedge sys_clk_i) begin
      if (pop && bb_r[brp_r][g]) begin
        mem[ba_r[brp_r]] <= bd_r[brp_r][g*LANE_W +: LANE_W];
      end
    end
  end

  // Output register
  logic [DW-1:0] dq_r;
  logic [DW-1:0] dq_nxt;
  logic          oe_nxt;

  always_comb begin
    dq_nxt = dq_r;
    oe_nxt = data_oe_o;
    if (en) begin
      oe_nxt = src.drive;
      if (src.rd) begin
        dq_nxt = rd_word;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dq_r      <= '0;
      data_oe_o <= 1'b0;
    end else begin
      dq_r      <= dq_nxt;
      data_oe_o <= oe_nxt;
    end
  end

  assign data_lane_a_o = dq_r[LANE_W-1:0];
  assign data_lane_b_o = dq_r[DW-1:LANE_W];
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_load_il; en && load && burst_order_select_i; endsequence
  sequence s_adv_il; en && !load && burst_order_select_i; endsequence
  sequence s_load_ln; en && load && !burst_order_select_i; endsequence
  sequence s_adv_ln; en && !load && !burst_order_select_i; endsequence
  sequence s_rd_cmd; en && load && sel && read_write_n_i && !output_enable_n_i; endsequence
  sequence s_wr_cmd; en && load && sel && !read_write_n_i && |be_in; endsequence
  chk_interleave_step: assert property (s_load_il ##1 s_adv_il |=>
    a1_r[1:0] == ($past(a1_r[1:0]) ^ 2'h1)) else $error("interleaved step wrong");
  chk_linear_step: assert property (s_load_ln ##1 s_adv_ln |=>
    a1_r[1:0] == $past(a1_r[1:0]) + 2'h1) else $error("linear step wrong");
  chk_burst_wrap: assert property ((en && load) ##1 (en && !load) [*4] |=>
    a1_r == $past(a1_r, 4)) else $error("burst did not wrap after four");
  chk_deselect_idle: assert property (en && load && !sel |=>
    (!p1_r.rd && p1_r.be == '0) and (en && flowthrough_select_n_i |=> !data_oe_o))
    else $error("deselect did not release pins");
  chk_read_pipe: assert property ((s_rd_cmd and flowthrough_select_n_i) ##1 en |=>
    data_oe_o) else $error("pipelined read not driven");
  chk_read_flow: assert property ((s_rd_cmd and !flowthrough_select_n_i) |=>
    data_oe_o) else $error("flow-through read not driven");
  chk_write_quiet: assert property ((s_wr_cmd and flowthrough_select_n_i) ##1 en |=>
    !data_oe_o) else $error("write slot drove pins");
  chk_write_take: assert property (s_wr_cmd ##1 en ##1 (en && wr_buf_ready_o) |=>
    bcnt_r != '0) else $error("write data not taken");
  chk_abort_empty: assert property (en && load && sel && !read_write_n_i && be_in == '0
    |=> p1_r.be == '0) else $error("abort carried lane enables");
  chk_inhibit_hold: assert property (!en |=> $stable(a1_r) && $stable(cnt_r) &&
    $stable(dq_r)) else $error("state moved during inhibit");
  chk_inhibit_drive: assert property (!en |=> data_oe_o == $past(data_oe_o))
    else $error("drive changed during inhibit");
  chk_reset_release: assert property ($past(sys_rst_i) |-> !data_oe_o)
    else $error("pins driven after reset");
endmodule

/* design/sbs_pkg.sv */
// Purpose: Types of the burst SRAM core
// Assumes: sbs_regs.svh on the include path
// Notes:   One-hot burst operation codes
`include "sbs_regs.svh"
package sbs_pkg;
  typedef enum logic [2:0] {
    SBS_DESEL = 3'b001,
    SBS_READ  = 3'b010,
    SBS_WRITE = 3'b100
  } sbs_op_t;

  typedef struct packed {
    logic                   rd;
    logic                   drive;
    logic [`SBS_LANES-1:0]  be;
  } sbs_slot_t;
endpackage

/* design/sbs_regs.svh */
// Purpose: Constants of the burst SRAM core
// Assumes: Included by the package and the core
// Notes:   Latencies are counted in enabled clock edges
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_ADDR_W     19
`define SBS_LANE_W     9
`define SBS_LANES      2
`define SBS_CNT_W      2
`define SBS_RD_LAT_PIP 2
`define SBS_RD_LAT_FLO 1
`define SBS_WR_LAT     2
`define SBS_BUF_DEPTH  2
`endif

/* test/sbs_ctrl_model.sv */
// Purpose: Controller model: commands, address and late write data
// Assumes: One call of put occupies one rising edge
// Notes:   Idle data lines show the inverse of their last value
`timescale 1ns/1ps
module sbs_ctrl_model (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  output logic             clock_enable_n_o,
  output logic             chip_enable_low_a_n_o,
  output logic             chip_enable_high_o,
  output logic             chip_enable_low_b_n_o,
  output logic             advance_or_load_o,
  output logic             read_write_n_o,
  output logic             byte_lane_a_write_n_o,
  output logic             byte_lane_b_write_n_o,
  output logic             output_enable_n_o,
  output logic [7:0]       addr_o,
  output logic [17:0]      wdata_o
);
  logic [17:0] word_r = 18'h00000;
  logic [17:0] last_r = 18'h00000;
  logic [18:0] wr1_r;
  logic [18:0] wr2_r;
  logic        wr_burst_r;
  logic        sel;
  logic        wr_now;
  assign sel = {chip_enable_low_a_n_o, chip_enable_high_o, chip_enable_low_b_n_o} == 3'h2;
  assign wr_now = (advance_or_load_o ? wr_burst_r : sel & !read_write_n_o)
                  & !(byte_lane_a_write_n_o & byte_lane_b_write_n_o);
  assign wdata_o = wr2_r[18] ? wr2_r[17:0] : ~last_r;
  always @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr1_r <= 19'h00000;
      wr2_r <= 19'h00000;
      wr_burst_r <= 1'b0;
    end else if (!clock_enable_n_o) begin
      wr1_r <= {wr_now, word_r};
      wr2_r <= wr1_r;
      if (!advance_or_load_o) wr_burst_r <= sel & !read_write_n_o;
    end
  end
  always @(posedge sys_clk_i) last_r <= wdata_o;
  initial begin
    clock_enable_n_o = 1'b0;
    advance_or_load_o = 1'b0;
    {chip_enable_low_a_n_o, chip_enable_high_o, chip_enable_low_b_n_o} = 3'h4;
    read_write_n_o = 1'b1;
    {byte_lane_b_write_n_o, byte_lane_a_write_n_o} = 2'h3;
    output_enable_n_o = 1'b0;
    addr_o = 8'h00;
  end
  task automatic put(input logic [1:0] ca, input logic [2:0] ce, input logic rw,
                     input logic [1:0] be_n, input logic oe_n, input logic [7:0] a,
                     input logic [17:0] d);
    @(posedge sys_clk_i);
    {clock_enable_n_o, advance_or_load_o} <= ca;
    {chip_enable_low_a_n_o, chip_enable_high_o, chip_enable_low_b_n_o} <= ce;
    read_write_n_o <= rw;
    {byte_lane_b_write_n_o, byte_lane_a_write_n_o} <= be_n;
    output_enable_n_o <= oe_n;
    addr_o <= a;
    word_r <= d;
  endtask
  // Ignored pins are scrambled so a device that looks at them shows it
  task automatic nx(input logic [1:0] be_n, input logic oe_n, input logic [17:0] d);
    put(2'h1, 3'h5, ~read_write_n_o, be_n, oe_n, ~addr_o, d);
  endtask
  task automatic hold();
    put(2'h2, 3'h2, ~read_write_n_o, 2'h0, 1'b0, ~addr_o, 18'h00000);
  endtask
endmodule

/* test/tb.sv */
// Purpose: Self-checking bench of the burst SRAM core
// Assumes: ADDR_W reduced to 8; the controller model drives all commands
// Notes:   A cycle predictor judges the data pins at every falling edge
`timescale 1ns/1ps
module tb;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        flow_n    = 1'b1;
  logic        order     = 1'b0;
  logic        clock_enable_n;
  logic        advance_or_load;
  logic        read_write_n;
  logic        output_enable_n;
  logic [2:0]  chip_en;
  logic [1:0]  lane_wr_n;
  logic [7:0]  addr;
  logic [17:0] wdata;
  logic [17:0] rdata;
  logic        data_oe;
  logic        buf_rdy;
  logic [17:0] ref_mem [256];
  logic [7:0]  base_r;
  logic [7:0]  cur;
  logic [1:0]  cnt_r;
  logic [1:0]  op_r;
  logic [18:0] exp0;
  logic [18:0] exp1;
  logic [18:0] e;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sbs_ctrl_model ctl (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .clock_enable_n_o(clock_enable_n), .chip_enable_low_a_n_o(chip_en[2]),
    .chip_enable_high_o(chip_en[1]), .chip_enable_low_b_n_o(chip_en[0]),
    .advance_or_load_o(advance_or_load), .read_write_n_o(read_write_n),
    .byte_lane_a_write_n_o(lane_wr_n[0]), .byte_lane_b_write_n_o(lane_wr_n[1]),
    .output_enable_n_o(output_enable_n), .addr_o(addr), .wdata_o(wdata));
  sbs_core #(.ADDR_W(8)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .clock_enable_n_i(clock_enable_n), .chip_enable_low_a_n_i(chip_en[2]),
    .chip_enable_high_i(chip_en[1]), .chip_enable_low_b_n_i(chip_en[0]),
    .advance_or_load_i(advance_or_load), .read_write_n_i(read_write_n),
    .byte_lane_a_write_n_i(lane_wr_n[0]), .byte_lane_b_write_n_i(lane_wr_n[1]),
    .output_enable_n_i(output_enable_n), .burst_order_select_i(order),
    .flowthrough_select_n_i(flow_n), .addr_i(addr), .data_lane_a_i(wdata[8:0]),
    .data_lane_b_i(wdata[17:9]), .data_lane_a_o(rdata[8:0]),
    .data_lane_b_o(rdata[17:9]), .data_oe_o(data_oe), .wr_buf_ready_o(buf_rdy));
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] want);
    num_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Predictor sees the pins as sampled, before this edge's updates land
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      op_r = 2'h0;
      exp0 = 19'h00000;
      exp1 = 19'h00000;
    end else if (!clock_enable_n) begin
      if (!advance_or_load) begin
        op_r = chip_en != 3'h2 ? 2'h0 : read_write_n ? 2'h1 : 2'h2;
        base_r = addr;
        cnt_r = 2'h0;
      end else begin
        cnt_r = cnt_r + 2'h1;
      end
      cur = {base_r[7:2], order ? base_r[1:0] ^ cnt_r : base_r[1:0] + cnt_r};
      if (op_r == 2'h2 && !lane_wr_n[0]) ref_mem[cur][8:0] = ctl.word_r[8:0];
      if (op_r == 2'h2 && !lane_wr_n[1]) ref_mem[cur][17:9] = ctl.word_r[17:9];
      exp1 = exp0;
      exp0 = (op_r == 2'h1 && !output_enable_n) ? {1'b1, ref_mem[cur]} : 19'h00000;
    end
  end
  always @(negedge sys_clk_i) begin
    e = flow_n ? exp1 : exp0;
    check("data_oe_o", {17'h00000, data_oe}, {17'h00000, e[18]});
    check("wr_buf_ready_o", {17'h00000, buf_rdy}, 18'h00001);
    if (e[18]) check("read word", rdata, e[17:0]);
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic do_reset(input logic ft_n);
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    flow_n <= ft_n;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
  endtask
  task automatic idle();
    repeat (3) ctl.put(2'h0, 3'h4, 1'b0, 2'h0, 1'b0, 8'h00, 18'h00000);
  endtask
  task automatic t_order(input logic ord, input logic [7:0] base);
    order <= ord;
    ctl.put(2'h0, 3'h2, 1'b0, 2'h0, 1'b0, base + 8'h01, {base, 10'h15a});
    for (int i = 1; i < 4; i++) ctl.nx(2'h0, 1'b0, {base, 2'(i), 8'h5a});
    for (int s = 0; s < 4; s++) begin
      ctl.put(2'h0, 3'h2, 1'b1, 2'h0, 1'b0, base + 8'(s), 18'h00000);
      repeat (4) ctl.nx(2'h0, 1'b0, 18'h00000);
    end
    idle();
  endtask
  task automatic t_lanes();
    ctl.put(2'h0, 3'h2, 1'b0, 2'h2, 1'b0, 8'h40, 18'h00000);
    ctl.nx(2'h1, 1'b0, 18'h3ffff);
    ctl.nx(2'h3, 1'b0, 18'h15555);
    ctl.put(2'h0, 3'h2, 1'b0, 2'h3, 1'b0, 8'h43, 18'h2aaaa);
    ctl.put(2'h0, 3'h2, 1'b1, 2'h3, 1'b0, 8'h40, 18'h00000);
    repeat (3) ctl.nx(2'h3, 1'b0, 18'h00000);
    idle();
  endtask
  task automatic t_desel();
    for (int i = 0; i < 3; i++) begin
      ctl.put(2'h0, 3'h2 ^ 3'(1 << i), 1'b1, 2'h0, 1'b0, 8'h40, 18'h00000);
      ctl.nx(2'h0, 1'b0, 18'h00000);
    end
    ctl.put(2'h0, 3'h2, 1'b1, 2'h0, 1'b1, 8'h41, 18'h00000);
    ctl.nx(2'h0, 1'b1, 18'h00000);
    ctl.nx(2'h0, 1'b0, 18'h00000);
    idle();
  endtask
  task automatic t_inhibit();
    ctl.put(2'h0, 3'h2, 1'b0, 2'h0, 1'b0, 8'h60, 18'h0abcd);
    ctl.hold();
    ctl.nx(2'h0, 1'b0, 18'h1234f);
    ctl.hold();
    ctl.nx(2'h0, 1'b0, 18'h2c3a5);
    ctl.put(2'h0, 3'h2, 1'b1, 2'h0, 1'b0, 8'h60, 18'h00000);
    ctl.nx(2'h0, 1'b0, 18'h00000);
    repeat (2) ctl.hold();
    ctl.nx(2'h0, 1'b0, 18'h00000);
    idle();
  endtask
  task automatic t_flow();
    do_reset(1'b0);
    ctl.put(2'h0, 3'h2, 1'b0, 2'h0, 1'b0, 8'h70, 18'h31111);
    ctl.nx(2'h0, 1'b0, 18'h0eeee);
    ctl.put(2'h0, 3'h2, 1'b1, 2'h0, 1'b0, 8'h40, 18'h00000);
    ctl.put(2'h0, 3'h2, 1'b1, 2'h0, 1'b0, 8'h70, 18'h00000);
    ctl.nx(2'h0, 1'b0, 18'h00000);
    idle();
  endtask
  initial begin
    do_reset(1'b1);
    t_order(1'b0, 8'h20);
    t_order(1'b1, 8'h40);
    t_lanes();
    t_desel();
    t_inhibit();
    t_flow();
    conclude();
  end
endmodule
